// [src/vrc_defines.svh]
// Function
// - Output-enable bit set connects the programmable reference to its pin.
// - Pin reference output forces digital driver and input detector off.
// - Port read of the pin returns zero while reference output enabled.
// - Output enable overrides the pin's port direction bit two.
// - Wake from sleep leaves the programmable control register unchanged.
// - Reset clears programmable and fixed reference enable bits.
// - Reset clears range select (high range) and the level field.
// - Reset clears pin output enable, giving the pin back to ports.
// - Fixed reference request is own enable OR oscillator, detector, brownout.
// - Fixed control bit 7 is read/write enable; 1 powers reference on.
// - Clear fixed enable only withdraws its own request, never forces off.
// - Fixed control bit 6 is read-only stable flag, reset value zero.
// - Programmable control bit 7 powers the divider on or down.
// - Programmable control bit 6 is pin output enable, resets to zero.
// - Bit 5 selects range: 1 low in 24 steps, 0 high in 32.
// - Bit 4 selects source: 1 external reference pins, 0 supply rails.
// - Bits 3 to 0 are level 0 to 15 passed to divider taps.
// - Fixed control bits 5 to 0 ignore writes and read zero.
// - Only the enable gates divider current; other fields select taps.
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define VRC_ADDR_W          12
`define VRC_PROG_CTRL_OFS   12'h000
`define VRC_FIXED_CTRL_OFS  12'h004
`define VRC_REQ_STATUS_OFS  12'h008

// ****************************************
// Field positions
// ****************************************
`define VRC_PROG_EN_BIT     7
`define VRC_PROG_OE_BIT     6
`define VRC_PROG_RANGE_BIT  5
`define VRC_PROG_SRC_BIT    4
`define VRC_PROG_LVL_MSB    3
`define VRC_PROG_LVL_LSB    0
`define VRC_FIXED_EN_BIT    7
`define VRC_FIXED_ST_BIT    6

// ****************************************
// Reset values
// ****************************************
`define VRC_PROG_CTRL_RST   8'h00
`define VRC_FIXED_EN_RST    1'b0
`define VRC_DATA_ZERO       32'h0000_0000

`endif

// [src/vrc_pkg.sv]
package vrc_pkg;

  typedef logic [7:0] vrc_byte_t;

  // APB response sequencing
  typedef enum logic [1:0] {
    VRC_BUS_IDLE = 2'b00,
    VRC_BUS_RESP = 2'b01
  } vrc_bus_state_e;

  // Programmable reference control fields, bit 7 first
  typedef struct packed {
    logic       enable;
    logic       pin_out_enable;
    logic       range_select;
    logic       source_select;
    logic [3:0] level;
  } vrc_prog_ctrl_s;

endpackage : vrc_pkg

// [src/vrc_pin_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface vrc_pin_if;
  logic ref_out_enable;
  logic dir_bit_two;
  logic latch_bit_two;
  logic pin_in_sync;
  logic drv_out;
  logic drv_oe;
  logic in_buf_en;
  logic port_rd;
  logic ref_connect;

  modport ctl (
    input  ref_out_enable,
    input  dir_bit_two,
    input  latch_bit_two,
    input  pin_in_sync,
    output drv_out,
    output drv_oe,
    output in_buf_en,
    output port_rd,
    output ref_connect
  );

  modport src (
    output ref_out_enable,
    output dir_bit_two,
    output latch_bit_two,
    output pin_in_sync,
    input  drv_out,
    input  drv_oe,
    input  in_buf_en,
    input  port_rd,
    input  ref_connect
  );
endinterface : vrc_pin_if

`default_nettype wire

// [src/vrc_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module vrc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_chk
    $error("vrc_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : vrc_sync

`default_nettype wire

// [src/vrc_pin_ctl.sv]
`timescale 1ns/10ps
`default_nettype none

module vrc_pin_ctl (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin control
  vrc_pin_if.ctl    pin
);

  // Direction bit one means input, so the driver runs only when it is zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin.drv_out     <= 1'b0;
      pin.drv_oe      <= 1'b0;
      pin.in_buf_en   <= 1'b1;
      pin.port_rd     <= 1'b0;
      pin.ref_connect <= 1'b0;
    end else begin
      pin.ref_connect <= pin.ref_out_enable;
      pin.drv_oe      <= !pin.ref_out_enable && !pin.dir_bit_two;
      pin.drv_out     <= pin.latch_bit_two && !pin.ref_out_enable;
      pin.in_buf_en   <= !pin.ref_out_enable;
      pin.port_rd     <= pin.pin_in_sync && !pin.ref_out_enable;
    end
  end

endmodule : vrc_pin_ctl

`default_nettype wire

// [src/vrc_top.sv]
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

`include "vrc_defines.svh"

module vrc_top (
  // ****************************************
  // Clock and reset
  // ****************************************
  input  wire logic                  clk,
  input  wire logic                  rst_b,

  // ****************************************
  // APB slave
  // ****************************************
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`VRC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,

  // ****************************************
  // Programmable reference analog controls
  // ****************************************
  output logic                       prog_ref_enable,
  output logic                       prog_ref_range_select,
  output logic                       prog_ref_source_select,
  output logic      [3:0]            prog_ref_level,
  output logic                       prog_ref_output_connect,

  // ****************************************
  // Fixed reference
  // ****************************************
  input  wire logic                  fixed_ref_stable_raw,
  input  wire logic                  internal_fast_oscillator_req,
  input  wire logic                  voltage_detector_req,
  input  wire logic                  brownout_reset_req,
  output logic                       fixed_ref_power_request,

  // ****************************************
  // Shared pin and port logic
  // ****************************************
  input  wire logic                  port_direction_bit_two,
  input  wire logic                  port_latch_bit_two,
  input  wire logic                  pad_in,
  output logic                       pad_out,
  output logic                       pad_oe,
  output logic                       pad_in_buf_en,
  output logic                       port_read_bit_two
);

  // ****************************************
  // Local declarations
  // ****************************************
  localparam int NSYNC = 5;

  vrc_pkg::vrc_bus_state_e bus_state_ff;
  vrc_pkg::vrc_bus_state_e nxt_bus_state;
  vrc_pkg::vrc_prog_ctrl_s prog_ctrl_ff;
  vrc_pkg::vrc_byte_t      prog_rd;
  vrc_pkg::vrc_byte_t      fixed_rd;
  vrc_pkg::vrc_byte_t      status_rd;

  logic             fixed_en_ff;
  logic             fixed_req_ff;
  logic [31:0]      prdata_ff;
  logic [31:0]      nxt_prdata;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             nxt_pslverr;

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_out;
  logic             stable_sync;
  logic             osc_req_sync;
  logic             det_req_sync;
  logic             bor_req_sync;
  logic             pin_in_sync;

  logic             access;
  logic             done;
  logic             wr_lane0;
  logic             sel_prog;
  logic             sel_fixed;
  logic             sel_status;
  logic             sel_none;

  vrc_pin_if        pin_bus ();

  // ****************************************
  // Crossings
  // ****************************************
  // The stable flag, the peripheral requests and the pad all come from
  // outside this clock, so each passes two flops before it is used.
  assign sync_in = {pad_in,
                    brownout_reset_req,
                    voltage_detector_req,
                    internal_fast_oscillator_req,
                    fixed_ref_stable_raw};

  vrc_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (sync_in),
    .q     (sync_out)
  );

  assign stable_sync  = sync_out[0];
  assign osc_req_sync = sync_out[1];
  assign det_req_sync = sync_out[2];
  assign bor_req_sync = sync_out[3];
  assign pin_in_sync  = sync_out[4];

  // ****************************************
  // APB decode
  // ****************************************
  assign access   = psel && penable;
  assign done     = access && pready_ff;
  assign wr_lane0 = done && pwrite && pstrb[0];

  always_comb begin
    sel_prog   = 1'b0;
    sel_fixed  = 1'b0;
    sel_status = 1'b0;
    sel_none   = 1'b0;
    if (paddr == `VRC_PROG_CTRL_OFS) begin
      sel_prog = 1'b1;
    end else if (paddr == `VRC_FIXED_CTRL_OFS) begin
      sel_fixed = 1'b1;
    end else if (paddr == `VRC_REQ_STATUS_OFS) begin
      sel_status = 1'b1;
    end else begin
      sel_none = 1'b1;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  assign prog_rd = prog_ctrl_ff;

  // Only the two top bits exist; the rest are tied low
  always_comb begin
    fixed_rd                    = 8'h00;
    fixed_rd[`VRC_FIXED_EN_BIT] = fixed_en_ff;
    fixed_rd[`VRC_FIXED_ST_BIT] = stable_sync;
  end

  assign status_rd = {4'h0,
                      bor_req_sync,
                      det_req_sync,
                      osc_req_sync,
                      fixed_req_ff};

  always_comb begin
    nxt_prdata  = `VRC_DATA_ZERO;
    nxt_pslverr = 1'b0;
    if (sel_prog) begin
      nxt_prdata[7:0] = prog_rd;
    end else if (sel_fixed) begin
      nxt_prdata[7:0] = fixed_rd;
    end else if (sel_status) begin
      nxt_prdata[7:0] = status_rd;
    end else begin
      nxt_pslverr = sel_none;
    end
  end

  // ****************************************
  // APB response
  // ****************************************
  // One wait state keeps pready and prdata straight from flops
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      vrc_pkg::VRC_BUS_IDLE: begin
        if (access) begin
          nxt_bus_state = vrc_pkg::VRC_BUS_RESP;
        end
      end
      vrc_pkg::VRC_BUS_RESP: begin
        nxt_bus_state = vrc_pkg::VRC_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = vrc_pkg::VRC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_ff <= vrc_pkg::VRC_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `VRC_DATA_ZERO;
    end else if (bus_state_ff == vrc_pkg::VRC_BUS_IDLE && access) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= pwrite ? `VRC_DATA_ZERO : nxt_prdata;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= `VRC_DATA_ZERO;
    end
  end

  // ****************************************
  // Programmable reference control register
  // ****************************************
  // Only reset and a bus write touch it; waking from sleep does not,
  // so the settings survive. Software should drop the enable before
  // sleep, since the divider keeps drawing current otherwise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_ctrl_ff <= `VRC_PROG_CTRL_RST;
    end else if (wr_lane0 && sel_prog) begin
      prog_ctrl_ff.enable         <= pwdata[`VRC_PROG_EN_BIT];
      prog_ctrl_ff.pin_out_enable <= pwdata[`VRC_PROG_OE_BIT];
      prog_ctrl_ff.range_select   <= pwdata[`VRC_PROG_RANGE_BIT];
      prog_ctrl_ff.source_select  <= pwdata[`VRC_PROG_SRC_BIT];
      prog_ctrl_ff.level <=
        pwdata[`VRC_PROG_LVL_MSB:`VRC_PROG_LVL_LSB];
    end
  end

  // ****************************************
  // Fixed reference control
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fixed_en_ff <= `VRC_FIXED_EN_RST;
    end else if (wr_lane0 && sel_fixed) begin
      fixed_en_ff <= pwdata[`VRC_FIXED_EN_BIT];
    end
  end

  // A clear enable only drops this block's own vote
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fixed_req_ff <= 1'b0;
    end else begin
      fixed_req_ff <= fixed_en_ff || osc_req_sync ||
                      det_req_sync || bor_req_sync;
    end
  end

  // ****************************************
  // Pin override
  // ****************************************
  assign pin_bus.ref_out_enable = prog_ctrl_ff.pin_out_enable;
  assign pin_bus.dir_bit_two    = port_direction_bit_two;
  assign pin_bus.latch_bit_two  = port_latch_bit_two;
  assign pin_bus.pin_in_sync    = pin_in_sync;

  vrc_pin_ctl u_pin (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (pin_bus.ctl)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // Divider current follows the enable alone; the other fields only
  // pick the tap, whatever the comparators are doing.
  assign prog_ref_enable        = prog_ctrl_ff.enable;
  assign prog_ref_range_select  = prog_ctrl_ff.range_select;
  assign prog_ref_source_select = prog_ctrl_ff.source_select;
  assign prog_ref_level         = prog_ctrl_ff.level;

  assign fixed_ref_power_request = fixed_req_ff;

  assign prog_ref_output_connect = pin_bus.ref_connect;
  assign pad_out                 = pin_bus.drv_out;
  assign pad_oe                  = pin_bus.drv_oe;
  assign pad_in_buf_en           = pin_bus.in_buf_en;
  assign port_read_bit_two       = pin_bus.port_rd;

endmodule : vrc_top

`default_nettype wire

// [verification/vrc_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vrc_defines.svh"
module vrc_asserts (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`VRC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // References
  input wire logic                   prog_ref_enable,
  input wire logic                   prog_ref_range_select,
  input wire logic                   prog_ref_source_select,
  input wire logic [3:0]             prog_ref_level,
  input wire logic                   prog_ref_output_connect,
  input wire logic                   brownout_reset_req,
  input wire logic                   fixed_ref_power_request,
  // Pin
  input wire logic                   pad_oe,
  input wire logic                   pad_out,
  input wire logic                   pad_in_buf_en,
  input wire logic                   port_read_bit_two
);
  logic       wr_prog;
  logic [6:0] fld;
  assign wr_prog = psel && penable && pready && pwrite && pstrb[0] &&
                   paddr == `VRC_PROG_CTRL_OFS;
  assign fld = {prog_ref_enable, prog_ref_range_select,
                prog_ref_source_select, prog_ref_level};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_fields;
    wr_prog |=> fld == {$past(pwdata[7]), $past(pwdata[5:0])};
  endproperty
  a_fields: assert property (p_fields)
    else $error("control fields wrong");
  property p_connect;
    wr_prog |-> ##2 prog_ref_output_connect == $past(pwdata[6], 2);
  endproperty
  a_connect: assert property (p_connect)
    else $error("connect wrong");
  property p_pin_off;
    prog_ref_output_connect |-> !pad_oe && !pad_out && !pad_in_buf_en;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin driver on");
  property p_read_zero;
    prog_ref_output_connect |-> !port_read_bit_two;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("port read not zero");
  property p_hold;
    $changed(fld) |-> $past(wr_prog);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control changed alone");
  property p_reset;
    $rose(rst_b) |-> fld == 7'h00 && !prog_ref_output_connect &&
                     !fixed_ref_power_request;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset value wrong");
  property p_or_req;
    brownout_reset_req [*4] |-> fixed_ref_power_request;
  endproperty
  a_or_req: assert property (p_or_req)
    else $error("request missing");
  property p_fixed_rd;
    pready && !pwrite && paddr == `VRC_FIXED_CTRL_OFS |->
      prdata[5:0] == 6'h00 && prdata[31:8] == 24'h00_0000;
  endproperty
  a_fixed_rd: assert property (p_fixed_rd)
    else $error("unused bits set");
  c_oe: cover property (wr_prog && pwdata[6]);
  c_err: cover property (pslverr);
  c_req: cover property (brownout_reset_req [*4]);
endmodule : vrc_asserts

bind vrc_top vrc_asserts u_vrc_asserts (.*);
`default_nettype wire

// [verification/vrc_analog_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vrc_analog_model #(
  parameter int SETTLE = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Fixed reference
  input  wire logic fixed_ref_power_request,
  output logic      fixed_ref_stable_raw,
  // Pin
  input  wire logic pad_oe,
  input  wire logic pad_out,
  input  wire logic ext_en,
  input  wire logic ext_v,
  output logic      pad_in
);
  int   cnt;
  logic tgl;
  // Settles only while powered; losing power drops it at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      cnt <= 0;
    else if (!fixed_ref_power_request)
      cnt <= 0;
    else if (cnt < SETTLE)
      cnt <= cnt + 1;
  end
  assign fixed_ref_stable_raw = (cnt == SETTLE);
  // An undriven pin wanders so that a stale read cannot pass
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      tgl <= 1'b0;
    else
      tgl <= !tgl;
  end
  assign pad_in = pad_oe ? pad_out : (ext_en ? ext_v : tgl);
endmodule : vrc_analog_model
`default_nettype wire

// [verification/voltage_reference_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vrc_defines.svh"
module voltage_reference_control_test;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    logic [7:0]  o;
  } vrc_row_s;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, prog_ref_level;
  logic prog_ref_enable, prog_ref_range_select, prog_ref_source_select;
  logic prog_ref_output_connect, fixed_ref_stable_raw, fixed_ref_power_request;
  logic internal_fast_oscillator_req, voltage_detector_req, brownout_reset_req;
  logic port_direction_bit_two, port_latch_bit_two, pad_in, pad_out, pad_oe;
  logic pad_in_buf_en, port_read_bit_two, ext_en, ext_v;
  logic [2:0] reqs;
  logic [7:0] outs;
  logic [4:0] pins;
  int fails, compares, n;
  vrc_row_s rows [8];
  assign {brownout_reset_req, voltage_detector_req,
          internal_fast_oscillator_req} = reqs;
  assign outs = {prog_ref_enable, prog_ref_output_connect,
                 prog_ref_range_select, prog_ref_source_select, prog_ref_level};
  assign pins = {prog_ref_output_connect, pad_oe, pad_out, pad_in_buf_en,
                 port_read_bit_two};
  vrc_top u_vrc_top (.*);
  vrc_analog_model u_vrc_analog_model (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      $display("Error %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic final_report;
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    {rst_b, psel, penable, pwrite, ext_en, ext_v} = 6'h00;
    {paddr, pwdata, reqs} = 47'h0;
    pstrb = 4'h1;
    port_direction_bit_two = 1'b1;
    port_latch_bit_two = 1'b0;
    rows[0] = '{`VRC_PROG_CTRL_OFS, 32'h0000_0080, 32'h80, 1'b0, 8'h80};
    rows[1] = '{`VRC_PROG_CTRL_OFS, 32'h0000_007F, 32'h7F, 1'b0, 8'h7F};
    rows[2] = '{`VRC_PROG_CTRL_OFS, 32'h0000_0025, 32'h25, 1'b0, 8'h25};
    rows[3] = '{`VRC_PROG_CTRL_OFS, 32'h0000_00DA, 32'hDA, 1'b0, 8'hDA};
    rows[4] = '{`VRC_PROG_CTRL_OFS, 32'hFFFF_FF10, 32'h10, 1'b0, 8'h10};
    rows[5] = '{12'h00C, 32'h0000_00FF, 32'h00, 1'b1, 8'h10};
    rows[6] = '{`VRC_REQ_STATUS_OFS, 32'h0000_00FF, 32'h00, 1'b0, 8'h10};
    rows[7] = '{`VRC_FIXED_CTRL_OFS, 32'h0000_003F, 32'h00, 1'b0, 8'h10};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(err, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(err, rows[i].e);
      chk(rd, rows[i].r);
      repeat (3) @(posedge clk);
      chk(outs, rows[i].o);
    end
    // Fixed reference: enable, settle, then other requesters alone
    apb(1'b1, `VRC_FIXED_CTRL_OFS, 32'h0000_00FF);
    apb(1'b0, `VRC_FIXED_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0080);
    chk(fixed_ref_power_request, 1'b1);
    n = 0;
    do begin
      apb(1'b0, `VRC_FIXED_CTRL_OFS, 32'h0000_0000);
      n++;
    end while (rd[6] !== 1'b1 && n < 20);
    chk(rd, 32'h0000_00C0);
    apb(1'b1, `VRC_FIXED_CTRL_OFS, 32'h0000_0000);
    repeat (6) @(posedge clk);
    chk(fixed_ref_power_request, 1'b0);
    for (int i = 0; i < 3; i++) begin
      reqs <= 3'b001 << i;
      repeat (5) @(posedge clk);
      chk(fixed_ref_power_request, 1'b1);
      apb(1'b0, `VRC_REQ_STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0001 | (32'h0000_0002 << i));
      reqs <= 3'b000;
      repeat (5) @(posedge clk);
      chk(fixed_ref_power_request, 1'b0);
    end
    // Pin: digital loopback, then the reference takes the pin over
    port_direction_bit_two <= 1'b0;
    port_latch_bit_two <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pins, 5'b0_1111);
    apb(1'b1, `VRC_PROG_CTRL_OFS, 32'h0000_0040);
    repeat (6) @(posedge clk);
    chk(pins, 5'b1_0000);
    port_direction_bit_two <= 1'b1;
    ext_en <= 1'b1;
    ext_v <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pins, 5'b1_0000);
    apb(1'b1, `VRC_PROG_CTRL_OFS, 32'h0000_0000);
    repeat (6) @(posedge clk);
    chk(pins, 5'b0_0111);
    // A write without byte lane 0 must leave the register alone
    pstrb <= 4'hE;
    apb(1'b1, `VRC_PROG_CTRL_OFS, 32'h0000_00FF);
    pstrb <= 4'h1;
    apb(1'b0, `VRC_PROG_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Reset in mid-run clears everything that was set
    apb(1'b1, `VRC_PROG_CTRL_OFS, 32'h0000_00FF);
    apb(1'b1, `VRC_FIXED_CTRL_OFS, 32'h0000_0080);
    chk(outs, 8'hFF);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `VRC_PROG_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `VRC_FIXED_CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(outs, 8'h00);
    final_report;
  end
endmodule : voltage_reference_control_test
`default_nettype wire
